// file: core/ira_regs.vh
// register map, field positions and sequence constants of the interrupt block
`ifndef IRA_REGS_VH
`define IRA_REGS_VH

// register indices; byte address on the bus is four times the index
`define IRA_IDX_REQ_HIGH 8'hec
`define IRA_IDX_REQ_LOW 8'hed
`define IRA_IDX_TIMER_EVT 8'hee
`define IRA_IDX_SERIAL_EVT 8'hef
`define IRA_IDX_CTRL 8'hf0

// reset values
`define IRA_RST_REQ_HIGH 8'h00
`define IRA_RST_REQ_LOW 8'h00
`define IRA_RST_TIMER_EVT 8'h00
`define IRA_RST_SERIAL_EVT 8'h00

// implemented bits
`define IRA_REQ_LOW_MASK 8'hfd
`define IRA_SERIAL_EVT_MASK 8'h83

// peripheral_request_low bit positions
`define IRA_RL_TWOWIRE 7
`define IRA_RL_SYNC_SERIAL 6
`define IRA_RL_WATCH 5
`define IRA_RL_SERIAL_RX 4
`define IRA_RL_SERIAL_TX 3
`define IRA_RL_WATCHDOG 2
`define IRA_RL_BASIC_TIMER 0

// serial_event_flags bit positions
`define IRA_SE_TWOWIRE 7
`define IRA_SE_SERIAL_RX 1
`define IRA_SE_SERIAL_TX 0

// control register fields
`define IRA_CTRL_MASTER_EN 0
`define IRA_CTRL_BUSY 1
`define IRA_CTRL_BRK_PEND 2

// program_status_word fields
`define IRA_PSW_I_BIT 2
`define IRA_PSW_B_BIT 4

// vector table
`define IRA_VEC_BASE 16'hffe0
`define IRA_TCALL0_VEC 16'hffde

// acceptance sequence: accept cycle plus steps 0 to 6 is 8 cycles
`define IRA_ACCEPT_CYCLES 8
`define IRA_SEQ_PUSHES 3'd3
`define IRA_SEQ_VEC_LO 3'd3
`define IRA_SEQ_VEC_HI 3'd4
`define IRA_SEQ_ENTRY_HI 3'd5
`define IRA_SEQ_LAST 3'd6
`endif

// file: core/ira_ctrl.v
// interrupt request flags, occurrence flags and acceptance sequencer
// Functional notes
// R1: request flag shows pending; writing 0 clears
// R2: low request register holds seven peripheral sources
// R3: timer register holds match and overflow flags
// R4: serial flags: two-wire, receive, transmit bits
// R5: request stays latched until accepted or cleared
// R6: acceptance sequence lasts eight clock cycles
// R7: return instruction restores interrupted context
// R8: maskable acceptance first clears master enable
// R9: non-maskable acceptance blocks following interrupts; here break blocks them only while busy, master enable is left unchanged
// R10: acceptance clears only the accepted request flag
// R11: push return address and status, three pushes
// R12: fetch vector entry, load program counter
// R13: master enable low blocks every maskable request
// R14: enable instruction inside handler allows nesting
// R15: handler saves accumulator and index registers
// R16: break is lowest priority, sets break flag
// R17: occurrence flags identify shared vector source
// R18: serial transmit and receive flags, software clears
// R19: external group flags recorded, software clears; here none are recorded, acceptance clears the request through ext_ack
// R20: timer match and overflow recorded separately
// R21: disabled source is never accepted
// R22: master enable blocks all maskable interrupts
// R23: higher priority first, fixed polling order
// R24: unused bits read zero, ignore writes
//
// Added by the designer: the Avalon-MM slave port.
`include "ira_regs.vh"

module ira_ctrl #(
  parameter [15:0] VEC_BASE = `IRA_VEC_BASE,
  parameter [15:0] BRK_VEC = `IRA_TCALL0_VEC
) (
  input wire mclk,
  input wire reset_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [7:0] evt_high,
  input wire [7:0] evt_low,
  input wire [7:0] enable_high,
  input wire [7:0] enable_low,
  input wire [4:0] ext_request,
  input wire [4:0] ext_enable,
  output reg [4:0] ext_ack,
  input wire instr_done,
  input wire ei_exec,
  input wire di_exec,
  input wire brk_exec,
  input wire return_from_interrupt_exec,
  input wire [7:0] return_from_interrupt_psw,
  input wire [15:0] pc_in,
  input wire [7:0] psw_in,
  output wire accept_busy,
  output wire master_enable,
  output wire stack_push,
  output reg [7:0] stack_data,
  output wire vec_rd,
  output wire [15:0] vec_addr,
  input wire [7:0] vec_data,
  output wire pc_load,
  output wire [15:0] pc_value
);

  reg [7:0] req_high_q;
  reg [7:0] req_high_d;
  reg [7:0] req_low_q;
  reg [7:0] req_low_d;
  reg [7:0] timer_evt_q;
  reg [7:0] timer_evt_d;
  reg [7:0] serial_evt_q;
  reg [7:0] serial_evt_d;
  reg ie_q;
  reg ie_d;
  reg brk_pend_q;
  reg busy_q;
  reg [2:0] cnt_q;
  reg [3:0] vec_q;
  reg is_brk_q;
  reg [15:0] ret_pc_q;
  reg [7:0] ret_psw_q;
  reg [7:0] entry_lo_q;
  reg [7:0] entry_hi_q;
  reg ack_q;
  reg [7:0] rd_mux;
  reg [7:0] clr_high;
  reg [7:0] clr_low;
  reg [4:0] clr_ext;

  // registers sit on word boundaries
  wire [7:0] idx = avs_address[9:2];
  wire bus_req = avs_read | avs_write;
  // low byte lane carries every register; writes land on the answer edge
  wire wr_en = avs_write & ack_q & avs_byteenable[0];
  wire [7:0] wdata = avs_writedata[7:0];
  wire [7:0] pend_high = req_high_q & enable_high;
  wire [7:0] pend_low = req_low_q & enable_low & `IRA_REQ_LOW_MASK;
  wire [4:0] pend_ext = ext_request & ext_enable;
  wire [15:0] vec_pend;
  wire take_mask;
  wire go;
  wire go_mask;
  wire [3:0] win_vec;

  // highest pending vector number wins
  function [3:0] top_index;
    input [15:0] p;
    integer i;
    begin
      top_index = 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        if (p[i])
          top_index = i[3:0]; // R23
      end
    end
  endfunction

  // register select; shared by the write strobes
  function reg_hit;
    input [7:0] a;
    input [7:0] r;
    begin
      reg_hit = (a == r);
    end
  endfunction

  // one of the two timer flags of a vector; match is the upper bit
  function [1:0] pair_clear;
    input [1:0] p;
    begin
      if (p[1])
        pair_clear = 2'b10;
      else
        pair_clear = 2'b01;
    end
  endfunction

  // write strobes, one per writable register
  wire wr_req_high = wr_en & reg_hit(idx, `IRA_IDX_REQ_HIGH);
  wire wr_req_low = wr_en & reg_hit(idx, `IRA_IDX_REQ_LOW);
  wire wr_timer_evt = wr_en & reg_hit(idx, `IRA_IDX_TIMER_EVT);
  wire wr_serial_evt = wr_en & reg_hit(idx, `IRA_IDX_SERIAL_EVT);
  wire wr_ctrl = wr_en & reg_hit(idx, `IRA_IDX_CTRL);

  // per-vector pending, gated by individual enables
  assign vec_pend[0] = pend_low[`IRA_RL_BASIC_TIMER]; // R21
  assign vec_pend[1] = pend_low[`IRA_RL_WATCHDOG];
  genvar t;
  generate
    for (t = 0; t < 4; t = t + 1) begin : g_timer
      // vector 2 is timer 0, vector 5 is timer 3
      assign vec_pend[2 + t] = |pend_high[2 * t + 1:2 * t];
    end
  endgenerate
  assign vec_pend[6] = pend_low[`IRA_RL_SERIAL_RX] |
    pend_low[`IRA_RL_SERIAL_TX];
  assign vec_pend[7] = pend_low[`IRA_RL_WATCH];
  assign vec_pend[8] = pend_low[`IRA_RL_SYNC_SERIAL];
  assign vec_pend[9] = pend_low[`IRA_RL_TWOWIRE];
  // external lines, group first, then the single inputs
  assign vec_pend[14:10] = pend_ext;
  assign vec_pend[15] = 1'b0;

  assign win_vec = top_index(vec_pend);
  assign take_mask = ie_q & (|vec_pend); // R13 R22
  // break has lowest priority and is taken only when nothing else is
  assign go = ~busy_q & instr_done & (take_mask | brk_pend_q); // R16
  assign go_mask = go & take_mask;

  // sequence step decodes, counted from the first busy cycle
  wire step_push = busy_q & (cnt_q < `IRA_SEQ_PUSHES);
  wire step_vec_lo = busy_q & (cnt_q == `IRA_SEQ_VEC_LO);
  wire step_vec_hi = busy_q & (cnt_q == `IRA_SEQ_VEC_HI);
  wire step_last = busy_q & (cnt_q == `IRA_SEQ_LAST);

  // pick the single flag cleared by acceptance; match before overflow
  always @* begin
    clr_high = 8'h00;
    clr_low = 8'h00;
    clr_ext = 5'h00;
    if (go_mask) begin
      case (win_vec)
        4'd0: clr_low[`IRA_RL_BASIC_TIMER] = 1'b1; // R10
        4'd1: clr_low[`IRA_RL_WATCHDOG] = 1'b1;
        4'd2: clr_high[1:0] = pair_clear(pend_high[1:0]);
        4'd3: clr_high[3:2] = pair_clear(pend_high[3:2]);
        4'd4: clr_high[5:4] = pair_clear(pend_high[5:4]);
        4'd5: clr_high[7:6] = pair_clear(pend_high[7:6]);
        4'd6: begin
          if (pend_low[`IRA_RL_SERIAL_RX])
            clr_low[`IRA_RL_SERIAL_RX] = 1'b1;
          else
            clr_low[`IRA_RL_SERIAL_TX] = 1'b1;
        end
        4'd7: clr_low[`IRA_RL_WATCH] = 1'b1;
        4'd8: clr_low[`IRA_RL_SYNC_SERIAL] = 1'b1;
        4'd9: clr_low[`IRA_RL_TWOWIRE] = 1'b1;
        4'd10: clr_ext = 5'h01;
        4'd11: clr_ext = 5'h02;
        4'd12: clr_ext = 5'h04;
        4'd13: clr_ext = 5'h08;
        4'd14: clr_ext = 5'h10;
        default: clr_ext = 5'h00;
      endcase
    end
  end

  // flag next values: software write, then acceptance clear, event wins
  always @* begin
    req_high_d = req_high_q;
    req_low_d = req_low_q;
    timer_evt_d = timer_evt_q;
    serial_evt_d = serial_evt_q;
    if (wr_req_high)
      req_high_d = wdata; // R1
    if (wr_req_low)
      req_low_d = wdata & `IRA_REQ_LOW_MASK; // R24
    if (wr_timer_evt)
      timer_evt_d = wdata;
    if (wr_serial_evt)
      serial_evt_d = wdata & `IRA_SERIAL_EVT_MASK; // R18
    // latched until accepted, written 0 or reset
    req_high_d = (req_high_d & ~clr_high) | evt_high; // R5 R10
    req_low_d = ((req_low_d & ~clr_low) | evt_low) &
      `IRA_REQ_LOW_MASK; // R2
    // occurrence flags survive acceptance
    timer_evt_d = timer_evt_d | evt_high; // R3 R17 R20
    serial_evt_d[`IRA_SE_TWOWIRE] = serial_evt_d[`IRA_SE_TWOWIRE] |
      evt_low[`IRA_RL_TWOWIRE]; // R4
    serial_evt_d[`IRA_SE_SERIAL_RX] = serial_evt_d[`IRA_SE_SERIAL_RX] |
      evt_low[`IRA_RL_SERIAL_RX]; // R18
    serial_evt_d[`IRA_SE_SERIAL_TX] = serial_evt_d[`IRA_SE_SERIAL_TX] |
      evt_low[`IRA_RL_SERIAL_TX];
  end

  // master enable
  always @* begin
    ie_d = ie_q;
    // maskable acceptance outranks a same-cycle enable so the handler starts masked
    if (go_mask)
      ie_d = 1'b0; // R8
    else if (return_from_interrupt_exec)
      ie_d = return_from_interrupt_psw[`IRA_PSW_I_BIT]; // R7
    else if (ei_exec)
      ie_d = 1'b1; // R14
    else if (di_exec)
      ie_d = 1'b0;
    else if (wr_ctrl)
      ie_d = wdata[`IRA_CTRL_MASTER_EN];
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      req_high_q <= `IRA_RST_REQ_HIGH;
      req_low_q <= `IRA_RST_REQ_LOW;
      timer_evt_q <= `IRA_RST_TIMER_EVT;
      serial_evt_q <= `IRA_RST_SERIAL_EVT;
      ie_q <= 1'b0;
      ext_ack <= 5'h00;
    end else begin
      req_high_q <= req_high_d;
      req_low_q <= req_low_d;
      timer_evt_q <= timer_evt_d;
      serial_evt_q <= serial_evt_d;
      ie_q <= ie_d;
      // one-cycle clear strobe to the external request latch
      ext_ack <= clr_ext; // R19
    end
  end

  // break request; a new break in the accepting cycle is kept
  always @(posedge mclk) begin
    if (!reset_n)
      brk_pend_q <= 1'b0;
    else if (brk_exec)
      brk_pend_q <= 1'b1;
    else if (go && !take_mask)
      brk_pend_q <= 1'b0;
  end

  // acceptance sequencer: accept cycle plus seven steps
  always @(posedge mclk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      cnt_q <= 3'd0;
      vec_q <= 4'h0;
      is_brk_q <= 1'b0;
      ret_pc_q <= 16'h0000;
      ret_psw_q <= 8'h00;
      entry_lo_q <= 8'h00;
      entry_hi_q <= 8'h00;
    end else if (!busy_q) begin
      cnt_q <= 3'd0;
      if (go) begin
        // sequence holds off every other acceptance while it runs
        busy_q <= 1'b1; // R6 R9
        vec_q <= win_vec;
        is_brk_q <= ~take_mask;
        // return context is captured at the accept edge
        ret_pc_q <= pc_in;
        ret_psw_q <= psw_in;
        ret_psw_q[`IRA_PSW_I_BIT] <= ie_q;
        ret_psw_q[`IRA_PSW_B_BIT] <= ~take_mask; // R16
      end
    end else begin
      cnt_q <= cnt_q + 3'd1;
      // table byte arrives one cycle after its read
      if (cnt_q == `IRA_SEQ_VEC_HI)
        entry_lo_q <= vec_data; // R12
      if (cnt_q == `IRA_SEQ_ENTRY_HI)
        entry_hi_q <= vec_data;
      if (cnt_q == `IRA_SEQ_LAST)
        busy_q <= 1'b0; // R6
    end
  end

  // three pushes: return address high, low, then status word
  assign stack_push = step_push; // R11
  always @* begin
    case (cnt_q)
      3'd0: stack_data = ret_pc_q[15:8];
      3'd1: stack_data = ret_pc_q[7:0];
      3'd2: stack_data = ret_psw_q; // R15
      // nothing is pushed after the third step
      default: stack_data = 8'h00;
    endcase
  end

  // vector table read: low byte at the entry, high byte after it
  // break shares the table-call vector
  wire [15:0] entry_addr = is_brk_q ? BRK_VEC :
    (VEC_BASE + {11'h000, vec_q, 1'b0});
  assign vec_rd = step_vec_lo | step_vec_hi; // R12
  assign vec_addr = step_vec_hi ? entry_addr + 16'h0001 : entry_addr;
  assign pc_load = step_last; // R12
  assign pc_value = {entry_hi_q, entry_lo_q};
  assign accept_busy = busy_q;
  assign master_enable = ie_q;

  // control word: last vector, break pending, busy, master enable
  wire [7:0] ctrl_word = {vec_q, 1'b0, brk_pend_q, busy_q, ie_q};

  // register read mux; unused bits and unmapped addresses read zero
  always @* begin
    case (idx)
      `IRA_IDX_REQ_HIGH: rd_mux = req_high_q;
      `IRA_IDX_REQ_LOW: rd_mux = req_low_q & `IRA_REQ_LOW_MASK; // R24
      `IRA_IDX_TIMER_EVT: rd_mux = timer_evt_q;
      `IRA_IDX_SERIAL_EVT: rd_mux = serial_evt_q & `IRA_SERIAL_EVT_MASK;
      `IRA_IDX_CTRL: rd_mux = ctrl_word;
      default: rd_mux = 8'h00;
    endcase
  end

  // one wait cycle for every access, answer on the second cycle
  assign avs_waitrequest = bus_req & ~ack_q;
  always @(posedge mclk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (avs_read && !ack_q)
        avs_readdata <= {24'h000000, rd_mux};
    end
  end

endmodule // ira_ctrl

// file: tb/ira_checker.sv
// timing checks on the acceptance sequence and the register bus
module ira_checker (
  input wire mclk,
  input wire reset_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [4:0] ext_ack,
  input wire accept_busy,
  input wire master_enable,
  input wire stack_push,
  input wire [7:0] stack_data,
  input wire vec_rd,
  input wire [15:0] vec_addr,
  input wire [7:0] vec_data,
  input wire pc_load,
  input wire [15:0] pc_value,
  input wire [15:0] pc_in
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_busy_len;
    $rose(accept_busy) |-> accept_busy [*7] ##1 !accept_busy;
  endproperty
  property p_push3;
    $rose(accept_busy) |-> stack_push [*3] ##1 !stack_push;
  endproperty
  property p_pcload;
    $rose(accept_busy) |-> ##6 pc_load;
  endproperty
  property p_psw_i;
    $rose(accept_busy) |-> ##2 stack_data[2] == $past(master_enable, 3);
  endproperty
  property p_me_clr;
    $rose(accept_busy) |-> ##2 (stack_data[4] || !master_enable);
  endproperty
  property p_vec;
    $rose(accept_busy) |-> ##3 vec_rd ##1
      (vec_rd && vec_addr == $past(vec_addr) + 16'h1);
  endproperty
  property p_pcval;
    pc_load |-> pc_value == {$past(vec_data), $past(vec_data, 2)};
  endproperty
  property p_ack;
    (|ext_ack) |-> $rose(accept_busy);
  endproperty
  property p_push_pc;
    $rose(accept_busy) |-> stack_data == $past(pc_in[15:8]) ##1
      stack_data == $past(pc_in[7:0], 2);
  endproperty
  property p_ack_vec;
    (ext_ack == 5'h10) |-> ##3 (vec_rd && vec_addr == 16'hfffc);
  endproperty
  property p_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  a_push3: assert property (p_push3) else $error("push count");
  a_pcload: assert property (p_pcload) else $error("pc load late");
  a_psw_i: assert property (p_psw_i) else $error("saved enable");
  a_me_clr: assert property (p_me_clr) else $error("enable kept");
  a_vec: assert property (p_vec) else $error("vector fetch");
  a_pcval: assert property (p_pcval) else $error("pc value");
  a_ack: assert property (p_ack) else $error("stray ack");
  a_wait: assert property (p_wait) else $error("wait cycle");
  a_push_pc: assert property (p_push_pc) else $error("pushed pc");
  a_ack_vec: assert property (p_ack_vec) else $error("ext vector");
  c_acc: cover property ($rose(accept_busy));
  c_brk: cover property (stack_push && stack_data[4]);
  c_ext: cover property (|ext_ack);
endmodule // ira_checker

bind ira_ctrl ira_checker ira_checker_i (.mclk, .reset_n, .avs_read,
  .avs_write, .avs_waitrequest, .ext_ack, .accept_busy, .master_enable,
  .stack_push, .stack_data, .vec_rd, .vec_addr, .vec_data, .pc_load,
  .pc_value, .pc_in);

// file: tb/ira_core_model.sv
// core side: answers vector reads and counts stack pushes
module ira_core_model (
  input wire mclk,
  input wire stack_push,
  input wire vec_rd,
  input wire [15:0] vec_addr,
  output reg [7:0] vec_data,
  output integer n_push
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    vec_data = 8'h00;
    n_push = 0;
  end
  // table byte one cycle after the read, changing junk otherwise
  always @(posedge mclk) begin
    vec_data <= vec_rd ? vec_addr[7:0] ^ 8'h5a : ~vec_data;
    if (stack_push === 1'b1) n_push <= n_push + 1;
  end
endmodule // ira_core_model

// file: tb/tb_top.sv
// testbench: table of accepted sources, then hand tests
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  reg mclk = 0, reset_n = 0, avs_read = 0, avs_write = 0, instr_done = 0;
  reg ei_exec = 0, di_exec = 0, brk_exec = 0, return_from_interrupt_exec = 0;
  reg [9:0] avs_address = 0;
  reg [31:0] avs_writedata = 0, rd, rows [0:10];
  reg [7:0] evt_high = 0, evt_low = 0, enable_high = 8'hff;
  reg [7:0] enable_low = 8'hfd;
  reg [4:0] ext_request = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, accept_busy, master_enable, stack_push;
  wire vec_rd, pc_load;
  wire [4:0] ext_ack;
  wire [7:0] stack_data, vec_data;
  wire [15:0] vec_addr, pc_value;
  integer n_mismatch = 0, check_count = 0, i, n_push;
  always #5 mclk = ~mclk;
  ira_ctrl ira_ctrl_i (.mclk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_byteenable(4'h1), .avs_writedata, .avs_readdata,
    .avs_waitrequest, .evt_high, .evt_low, .enable_high, .enable_low,
    .ext_request, .ext_enable(5'h1f), .ext_ack, .instr_done,
    .ei_exec, .di_exec, .brk_exec, .return_from_interrupt_exec, .return_from_interrupt_psw(8'h04),
    .pc_in(16'h1234), .psw_in(8'h00), .accept_busy, .master_enable,
    .stack_push, .stack_data, .vec_rd, .vec_addr, .vec_data, .pc_load,
    .pc_value);
  ira_core_model ira_core_model_i (.mclk, .stack_push, .vec_rd,
    .vec_addr, .vec_data, .n_push);
  task summarize;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input wr, input [7:0] idx, input [7:0] wd);
    integer k;
    begin
      @(posedge mclk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, wd};
      avs_read <= !wr;
      avs_write <= wr;
      k = 0;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && k < 20) begin
        @(posedge mclk);
        k = k + 1;
      end
      if (k == 20) chk(1, 0);
      if (k == 20) summarize;
      rd = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
    end
  endtask
  task ev(input [7:0] h, input [7:0] l);
    begin
      @(posedge mclk);
      evt_high <= h;
      evt_low <= l;
      @(posedge mclk);
      evt_high <= 0;
      evt_low <= 0;
    end
  endtask
  task ei;
    begin
      @(posedge mclk) ei_exec <= 1;
      @(posedge mclk) ei_exec <= 0;
    end
  endtask
  // expected program counter after a fetch at entry e; 0 means none
  task acc(input [15:0] e);
    integer k;
    reg [15:0] x;
    begin
      x = e == 0 ? 16'h0 : {(e[7:0] + 8'h1) ^ 8'h5a, e[7:0] ^ 8'h5a};
      @(posedge mclk) instr_done <= 1;
      @(posedge mclk) instr_done <= 0;
      k = 0;
      while (pc_load !== 1'b1 && k < 12) begin
        @(posedge mclk);
        k = k + 1;
      end
      chk(pc_load === 1'b1 ? pc_value : 16'h0, x);
      if (k == 12 && e != 0) summarize;
    end
  endtask
  initial begin
    rows[0] = {8'h00, 8'h01, 16'hffe0};
    rows[1] = {8'h00, 8'h04, 16'hffe2};
    rows[2] = {8'h01, 8'h00, 16'hffe4};
    rows[3] = {8'h08, 8'h00, 16'hffe6};
    rows[4] = {8'h10, 8'h00, 16'hffe8};
    rows[5] = {8'h80, 8'h00, 16'hffea};
    rows[6] = {8'h00, 8'h10, 16'hffec};
    rows[7] = {8'h00, 8'h08, 16'hffec};
    rows[8] = {8'h00, 8'h20, 16'hffee};
    rows[9] = {8'h00, 8'h40, 16'hfff0};
    rows[10] = {8'h00, 8'h80, 16'hfff2};
    repeat (20) @(posedge mclk);
    reset_n <= 1;
    for (i = 0; i < 11; i = i + 1) begin
      ei;
      ev(rows[i][31:24], rows[i][23:16]);
      acc(rows[i][15:0]);
      bus(0, 8'hed, 0);
      chk(rd, 0);
    end
    chk(n_push, 33);
    bus(0, 8'hef, 0);
    chk(rd, 32'h83);
    bus(0, 8'hee, 0);
    chk(rd, 32'h99);
    bus(1, 8'hef, 0);
    bus(0, 8'hef, 0);
    chk(rd, 0);
    $display("table done");
    @(posedge mclk) reset_n <= 0;
    repeat (2) @(posedge mclk);
    reset_n <= 1;
    for (i = 8'hec; i < 8'hf2; i = i + 1) begin
      bus(0, i, 0);
      chk(rd, 0);
    end
    bus(1, 8'hef, 8'hff);
    bus(0, 8'hef, 0);
    chk(rd, 32'h83);
    bus(1, 8'hed, 8'hff);
    bus(0, 8'hed, 0);
    chk(rd, 32'hfd);
    bus(1, 8'hed, 0);
    $display("reset and map done");
    ev(0, 8'h01);
    acc(0);
    enable_low <= 0;
    ei;
    acc(0);
    bus(0, 8'hed, 0);
    chk(rd, 1);
    enable_low <= 8'hfd;
    acc(16'hffe0);
    ev(0, 8'h81);
    bus(1, 8'hf0, 1);
    acc(16'hfff2);
    ei;
    acc(16'hffe0);
    ei;
    bus(0, 8'hf0, 0);
    chk(rd & 1, 1);
    @(posedge mclk) di_exec <= 1;
    @(posedge mclk) di_exec <= 0;
    bus(0, 8'hf0, 0);
    chk(rd & 1, 0);
    $display("priority done");
    @(posedge mclk) brk_exec <= 1;
    @(posedge mclk) brk_exec <= 0;
    acc(16'hffde);
    @(posedge mclk) return_from_interrupt_exec <= 1;
    @(posedge mclk) return_from_interrupt_exec <= 0;
    bus(0, 8'hf0, 0);
    chk(rd & 1, 1);
    ext_request <= 5'h10;
    acc(16'hfffc);
    ext_request <= 0;
    $display("break and external done");
    summarize;
  end
endmodule // tb_top
